// ### shared/sspt_pkg.sv
// Purpose: constants for the synchronous serial shift port
// Assumes: one instruction cycle equals one clk_sys_in cycle
// Notes: register map and field positions live here only
// How it works
// - an eight-bit shift register sits between a serial input pin, a serial output pin and a shift clock pin.
// - an internal shift clock means master mode and an external shift clock means slave mode.
// - nothing serial happens and no pin is driven unless the port-enable bit of the control register is one.
// - in master mode the shift clock period is 2, 4 or 8 instruction cycles for rate codes 00, 01 and 1x.
// - setting the busy flag starts shifting and the hardware clears it after eight bits.
// - clearing the busy flag early stops the shifting so that fewer than eight bits move.
// - with its enable set, completion of eight bits raises an interrupt request.
// - the shift clock rests low whenever nothing is shifting, in either phase option.
// - in master mode the port starts every exchange by driving the shift clock out.
// - in slave mode the clock pin is an input and the serial output drives only when its configuration bit is one.
// - in normal phase input is sampled on the rising edge and the register advances and drives on the falling edge.
// - in alternate phase input is sampled on the falling edge and output is driven on the rising edge.
// - the phase select is port g bit 6 of the configuration register, zero is normal, and it resets to zero.
package sspt_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_STATUS_WORD = 3'h1;
    localparam logic [2:0] ADDR_SHIFT = 3'h2;
    localparam logic [2:0] ADDR_PORT_G_CFG = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
    // control_reg fields
    localparam int BIT_PORT_ENABLE = 0;
    localparam int BIT_RATE_LOW = 1;
    localparam int BIT_RATE_HIGH = 2;
    // processor_status_word field
    localparam int BIT_BUSY = 0;
    // port g configuration fields
    localparam int BIT_PORT_G4 = 4;
    localparam int BIT_PORT_G5 = 5;
    localparam int BIT_PORT_G6 = 6;
    // interrupt status and mask field
    localparam int BIT_DONE = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int INSTR_CYCLES_PER_CLK = 1;
    // half of the shift clock period, in clk cycles, per rate code
    localparam logic [1:0] HALF_RATE_00 = 2'h1;
    localparam logic [1:0] HALF_RATE_01 = 2'h2;
    localparam logic [2:0] HALF_RATE_1X = 3'h4;

    typedef enum logic [1:0] {
        SSPT_IDLE = 2'b01,
        SSPT_RUN = 2'b10
    } sspt_state_type;

    function automatic logic [2:0] sspt_half_period(input logic [1:0] rate);
        if (rate[1]) begin
            return HALF_RATE_1X;
        end
        return rate[0] ? {1'b0, HALF_RATE_01} : {1'b0, HALF_RATE_00};
    endfunction : sspt_half_period
endpackage : sspt_pkg

// ### hw/sspt_sync.sv
// Purpose: two-flop synchronisers for the serial pins and clock edge finder
// Assumes: pins are asynchronous to clk_sys_in
// Notes: edges are found one flop after the synchroniser
`timescale 1ns/100ps
`default_nettype none
module sspt_sync (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic sk_pin_in,
    input wire logic si_pin_in,
    output logic sk_level_out,
    output logic si_level_out,
    output logic sk_rise_out,
    output logic sk_fall_out
);
    logic [1:0] meta_q;
    logic [1:0] meta_d;
    logic [1:0] stable_q;
    logic [1:0] stable_d;
    logic sk_prev_q;
    logic sk_prev_d;

    always_comb begin
        meta_d = {sk_pin_in, si_pin_in};
        stable_d = meta_q;
        sk_prev_d = stable_q[1];
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_q <= 2'h0;
            stable_q <= 2'h0;
            sk_prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            stable_q <= stable_d;
            sk_prev_q <= sk_prev_d;
        end
    end

    assign sk_level_out = stable_q[1];
    assign si_level_out = stable_q[0];
    assign sk_rise_out = stable_q[1] && !sk_prev_q;
    assign sk_fall_out = !stable_q[1] && sk_prev_q;
endmodule : sspt_sync
`default_nettype wire

// ### hw/sspt_port.sv
// Purpose: eight-bit synchronous serial shift port with register access
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: master clock derived from clk_sys_in, slave clock sampled
`timescale 1ns/100ps
`default_nettype none
module sspt_port #(
    parameter int DATA_W = 8
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [sspt_pkg::ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic si_pin_in,
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe_out,
    output logic so_pin_out,
    output logic so_pin_oe_out,
    output logic irq_out
);
    if (DATA_W != 8) begin : g_width_check
        $error("sspt_port serves an eight-bit shift register only");
    end

    logic sk_level;
    logic si_level;
    logic sk_rise_ext;
    logic sk_fall_ext;

    sspt_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .sk_pin_in(shift_clock_pin_in),
        .si_pin_in(si_pin_in),
        .sk_level_out(sk_level),
        .si_level_out(si_level),
        .sk_rise_out(sk_rise_ext),
        .sk_fall_out(sk_fall_ext)
    );

    // register state
    logic [2:0] control_reg_q, control_reg_d;
    logic [7:0] port_g_cfg_q, port_g_cfg_d;
    logic irq_mask_q, irq_mask_d;
    logic irq_stat_q, irq_stat_d;
    logic [7:0] rdata_q, rdata_d;
    // shift engine state
    sspt_pkg::sspt_state_type state_q, state_d;
    logic [DATA_W-1:0] serial_shift_reg_q, serial_shift_reg_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [2:0] div_q, div_d;
    logic sk_q, sk_d;
    logic si_hold_q, si_hold_d;
    logic so_q, so_d;
    logic sk_oe_q, sk_oe_d;
    logic so_oe_q, so_oe_d;
    logic irq_q, irq_d;

    logic port_enable;
    logic is_master;
    logic alt_phase;
    logic busy;
    logic running;
    logic tick;
    logic rise_ev;
    logic fall_ev;
    logic last_bit;
    logic wr_status;
    logic wr_shift;

    always_comb begin
        port_enable = control_reg_q[sspt_pkg::BIT_PORT_ENABLE];
        // internal clock when the clock pin is configured as output
        is_master = port_g_cfg_q[sspt_pkg::BIT_PORT_G5];
        alt_phase = port_g_cfg_q[sspt_pkg::BIT_PORT_G6];
        busy = (state_q == sspt_pkg::SSPT_RUN);
        running = busy && port_enable;
        tick = running && is_master && (div_q == sspt_pkg::sspt_half_period(
            control_reg_q[sspt_pkg::BIT_RATE_HIGH:sspt_pkg::BIT_RATE_LOW])
            - 3'h1);
        rise_ev = running && (is_master ? (tick && !sk_q) : sk_rise_ext);
        fall_ev = running && (is_master ? (tick && sk_q) : sk_fall_ext);
        last_bit = fall_ev && (bit_cnt_q == sspt_pkg::LAST_BIT);
        wr_status = wr_in && (addr_in == sspt_pkg::ADDR_STATUS_WORD);
        wr_shift = wr_in && (addr_in == sspt_pkg::ADDR_SHIFT);
    end

    // shift engine
    always_comb begin
        state_d = state_q;
        serial_shift_reg_d = serial_shift_reg_q;
        bit_cnt_d = bit_cnt_q;
        div_d = 3'h0;
        sk_d = 1'b0;
        si_hold_d = si_hold_q;
        so_d = so_q;
        if (running && is_master) begin
            // master drives every exchange from its own divider
            div_d = tick ? 3'h0 : div_q + 3'h1;
            sk_d = tick ? !sk_q : sk_q;
        end
        if (rise_ev && !alt_phase) begin
            si_hold_d = si_level;
        end
        if (fall_ev) begin
            // msb leaves first, sampled bit enters at the bottom
            serial_shift_reg_d = {serial_shift_reg_q[DATA_W-2:0],
                alt_phase ? si_level : si_hold_q};
            bit_cnt_d = bit_cnt_q + 3'h1;
        end
        if (!alt_phase && fall_ev) begin
            so_d = serial_shift_reg_q[DATA_W-2];
        end else if (alt_phase && rise_ev) begin
            so_d = serial_shift_reg_q[DATA_W-1];
        end else if (!busy) begin
            so_d = serial_shift_reg_q[DATA_W-1];
        end
        if (last_bit) begin
            state_d = sspt_pkg::SSPT_IDLE;
            bit_cnt_d = 3'h0;
        end
        if (wr_shift) begin
            // loading while the clock is high is left to software
            serial_shift_reg_d = wdata_in;
            so_d = wdata_in[DATA_W-1];
        end
        if (wr_status) begin
            // a software set wins over the hardware clear above
            if (wdata_in[sspt_pkg::BIT_BUSY]) begin
                state_d = sspt_pkg::SSPT_RUN;
            end else begin
                state_d = sspt_pkg::SSPT_IDLE;
                bit_cnt_d = 3'h0;
            end
        end
        if (state_d == sspt_pkg::SSPT_IDLE) begin
            sk_d = 1'b0;
            div_d = 3'h0;
        end
    end

    // registers, pins and interrupt
    always_comb begin
        control_reg_d = control_reg_q;
        port_g_cfg_d = port_g_cfg_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        rdata_d = 8'h00;
        if (wr_in) begin
            unique case (addr_in)
                sspt_pkg::ADDR_CONTROL: control_reg_d = wdata_in[2:0];
                sspt_pkg::ADDR_PORT_G_CFG: port_g_cfg_d = wdata_in;
                sspt_pkg::ADDR_IRQ_MASK: irq_mask_d = wdata_in[0];
                default: ;
            endcase
        end
        if (rd_in) begin
            unique case (addr_in)
                sspt_pkg::ADDR_CONTROL: rdata_d = {5'h00, control_reg_q};
                sspt_pkg::ADDR_STATUS_WORD: rdata_d = {7'h00, busy};
                sspt_pkg::ADDR_SHIFT: rdata_d = serial_shift_reg_q;
                sspt_pkg::ADDR_PORT_G_CFG: rdata_d = port_g_cfg_q;
                sspt_pkg::ADDR_IRQ_STATUS: rdata_d = {7'h00, irq_stat_q};
                sspt_pkg::ADDR_IRQ_MASK: rdata_d = {7'h00, irq_mask_q};
                default: rdata_d = 8'h00;
            endcase
            if (addr_in == sspt_pkg::ADDR_IRQ_STATUS) begin
                irq_stat_d = 1'b0;
            end
        end
        if (last_bit) begin
            irq_stat_d = 1'b1;
        end
        irq_d = irq_stat_d && irq_mask_d;
        // pins reach the port only with the port enabled
        sk_oe_d = control_reg_d[sspt_pkg::BIT_PORT_ENABLE]
            && port_g_cfg_d[sspt_pkg::BIT_PORT_G5];
        so_oe_d = control_reg_d[sspt_pkg::BIT_PORT_ENABLE]
            && port_g_cfg_d[sspt_pkg::BIT_PORT_G4];
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= sspt_pkg::SSPT_IDLE;
            serial_shift_reg_q <= sspt_pkg::RESET_BYTE;
            bit_cnt_q <= 3'h0;
            div_q <= 3'h0;
            sk_q <= 1'b0;
            si_hold_q <= 1'b0;
            so_q <= 1'b0;
            control_reg_q <= 3'h0;
            port_g_cfg_q <= sspt_pkg::RESET_BYTE;
            irq_mask_q <= 1'b0;
            irq_stat_q <= 1'b0;
            rdata_q <= 8'h00;
            sk_oe_q <= 1'b0;
            so_oe_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            serial_shift_reg_q <= serial_shift_reg_d;
            bit_cnt_q <= bit_cnt_d;
            div_q <= div_d;
            sk_q <= sk_d;
            si_hold_q <= si_hold_d;
            so_q <= so_d;
            control_reg_q <= control_reg_d;
            port_g_cfg_q <= port_g_cfg_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
            rdata_q <= rdata_d;
            sk_oe_q <= sk_oe_d;
            so_oe_q <= so_oe_d;
            irq_q <= irq_d;
        end
    end

    assign rdata_out = rdata_q;
    assign shift_clock_pin_out = sk_q;
    assign shift_clock_pin_oe_out = sk_oe_q;
    assign so_pin_out = so_q;
    assign so_pin_oe_out = so_oe_q;
    assign irq_out = irq_q;

    property p_sk_idle_low;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (!busy && !wr_status) |=> !sk_q;
    endproperty
    a_sk_idle_low: assert property (p_sk_idle_low)
        else $error("shift clock high while idle");

    property p_busy_clears;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (last_bit && !wr_status) |=> (!busy && bit_cnt_q == 3'h0);
    endproperty
    a_busy_clears: assert property (p_busy_clears)
        else $error("busy not cleared after eighth bit");

    property p_abort;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (wr_status && !wdata_in[0]) |=> (!busy ##1 !sk_q);
    endproperty
    a_abort: assert property (p_abort)
        else $error("shifting continued after software clear");

    property p_irq;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (last_bit && irq_mask_q && !wr_in) |=> (irq_out && irq_stat_q);
    endproperty
    a_irq: assert property (p_irq)
        else $error("completion did not raise interrupt");

    property p_slow_rate;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        ($rose(sk_q) && control_reg_q[sspt_pkg::BIT_RATE_HIGH] && !wr_in)
        |-> (sk_q || !busy)[*4] ##1 (!sk_q);
    endproperty
    a_slow_rate: assert property (p_slow_rate)
        else $error("slow shift clock half period not four cycles");

    property p_fast_rate;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (running && is_master && sk_q && control_reg_q[2:1] == 2'h0)
        |=> !sk_q;
    endproperty
    a_fast_rate: assert property (p_fast_rate)
        else $error("fast shift clock half period not one cycle");

    property p_pins_off;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (!control_reg_d[0] || !port_g_cfg_d[5]) |=> !shift_clock_pin_oe_out;
    endproperty
    a_pins_off: assert property (p_pins_off)
        else $error("clock pin driven while disabled or in slave mode");

    property p_normal_shift;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (fall_ev && !alt_phase && !wr_in) |=>
        (serial_shift_reg_q == {$past(serial_shift_reg_q[6:0]),
            $past(si_hold_q)}) && (so_q == serial_shift_reg_q[7]);
    endproperty
    a_normal_shift: assert property (p_normal_shift)
        else $error("normal phase shift wrong");

    property p_alt_drive;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (rise_ev && alt_phase && !wr_in) |=>
        (so_q == $past(serial_shift_reg_q[7]));
    endproperty
    a_alt_drive: assert property (p_alt_drive)
        else $error("alternate phase output not driven on rising edge");

    property p_count;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (fall_ev && !last_bit && !wr_in) |=>
        (bit_cnt_q == $past(bit_cnt_q) + 3'h1);
    endproperty
    a_count: assert property (p_count)
        else $error("bit counter did not advance");

    property p_disabled_hold;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (busy && !port_enable && !wr_in) |=>
        (!sk_q && bit_cnt_q == $past(bit_cnt_q)
            && serial_shift_reg_q == $past(serial_shift_reg_q));
    endproperty
    a_disabled_hold: assert property (p_disabled_hold)
        else $error("shifting while the port is disabled");

    property p_mid_rate;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        ($rose(sk_q) && !control_reg_q[sspt_pkg::BIT_RATE_HIGH]
            && control_reg_q[sspt_pkg::BIT_RATE_LOW] && !wr_in)
        |-> sk_q[*2] ##1 !sk_q;
    endproperty
    a_mid_rate: assert property (p_mid_rate)
        else $error("middle shift clock half period not two cycles");

    property p_done_sticky;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (irq_stat_q && !(rd_in && addr_in == sspt_pkg::ADDR_IRQ_STATUS))
        |=> irq_stat_q;
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("completion flag lost without a read");

    property p_done_read_clear;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (rd_in && addr_in == sspt_pkg::ADDR_IRQ_STATUS && !last_bit)
        |=> (!irq_stat_q && !irq_out);
    endproperty
    a_done_read_clear: assert property (p_done_read_clear)
        else $error("reading the status did not clear it");

    property p_slave_clock_low;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        !is_master |=> !shift_clock_pin_out;
    endproperty
    a_slave_clock_low: assert property (p_slave_clock_low)
        else $error("shift clock made internally in slave mode");
endmodule : sspt_port
`default_nettype wire

// ### verif/sspt_peer.sv
// Purpose: behavioural serial partner for the shift port
// Assumes: sk_line_in is the resolved clock wire, so_oe_in qualifies so_in
// Notes: as remote master it clocks 8 pulses, 160 ns high and 160 ns low, resting low
`timescale 1ns/100ps
`default_nettype none
module sspt_peer (
    input wire logic alt_in,
    input wire logic remote_in,
    input wire logic go_in,
    input wire logic [7:0] tx_in,
    input wire logic sk_line_in,
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic sk_out,
    output logic si_out,
    output logic [7:0] rx_out
);
    logic [7:0] tx_q;
    // an undriven output must not look like its last value
    wire logic so_line = so_oe_in ? so_in : ~so_in;
    initial begin
        sk_out = 1'b0;
        si_out = 1'b0;
        rx_out = 8'h00;
        tx_q = 8'h00;
    end
    always @(posedge go_in) begin
        tx_q = tx_in;
        rx_out = 8'h00;
        si_out = tx_q[7];
        if (remote_in) begin
            // odd offset keeps the link clock unrelated to clk_sys_in
            #7;
            repeat (8) begin
                #160 sk_out = 1'b1;
                #160 sk_out = 1'b0;
            end
        end
    end
    // filler bits toggle so a finished frame never holds its last bit
    always @(posedge sk_line_in) begin
        if (alt_in) begin
            si_out = tx_q[7];
            tx_q = {tx_q[6:0], ~tx_q[7]};
        end else begin
            rx_out = {rx_out[6:0], so_line};
        end
    end
    always @(negedge sk_line_in) begin
        if (alt_in) begin
            rx_out = {rx_out[6:0], so_line};
        end else begin
            tx_q = {tx_q[6:0], ~tx_q[7]};
            si_out = tx_q[7];
        end
    end
endmodule : sspt_peer
`default_nettype wire

// ### verif/testbench.sv
// Purpose: self-checking bench for the serial shift port
// Assumes: peer model on the serial pins, 25 MHz clock
// Notes: input data checked at slow rates only, the synchroniser lags
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [sspt_pkg::ADDR_W-1:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out, peer_rx;
    logic [7:0] peer_tx = 8'h00;
    logic sk_out, sk_oe, so_out, so_oe, irq_out, peer_sk, peer_si;
    logic alt = 1'b0;
    logic remote = 1'b0;
    logic go = 1'b0;
    logic sk_prev = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    int rises = 0;
    int last_rise = 0;
    int period = 0;
    wire logic sk_wire = sk_oe ? sk_out : peer_sk;

    sspt_port uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .si_pin_in(peer_si),
        .shift_clock_pin_in(sk_wire), .shift_clock_pin_out(sk_out),
        .shift_clock_pin_oe_out(sk_oe), .so_pin_out(so_out),
        .so_pin_oe_out(so_oe), .irq_out(irq_out));
    sspt_peer peer (.alt_in(alt), .remote_in(remote), .go_in(go),
        .tx_in(peer_tx), .sk_line_in(sk_wire), .so_in(so_out),
        .so_oe_in(so_oe), .sk_out(peer_sk), .si_out(peer_si),
        .rx_out(peer_rx));

    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        sk_prev <= sk_out;
        if (sk_out === 1'b1 && sk_prev === 1'b0) begin
            rises <= rises + 1;
            period <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rdchk(input string what, input logic [2:0] a,
            input logic [7:0] exp, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
        if (what != "") check(what, d, exp);
    endtask : rdchk
    task automatic wait_idle();
        logic [7:0] d;
        d = 8'h01;
        for (int i = 0; i < 200 && d[0] !== 1'b0; i++) begin
            rdchk("", sspt_pkg::ADDR_STATUS_WORD, 8'h00, d);
        end
    endtask : wait_idle
    task automatic pause(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : pause

    task automatic t_reset();
        logic [7:0] d;
        for (int a = 0; a < 8; a++) rdchk("reg reset", 3'(a), 8'h00, d);
        check("pins idle", {4'h0, sk_out, sk_oe, so_oe, irq_out}, 8'h00);
        wr(sspt_pkg::ADDR_IRQ_MASK, 8'h01);
        rdchk("mask", sspt_pkg::ADDR_IRQ_MASK, 8'h01, d);
    endtask : t_reset

    task automatic t_master(input logic [1:0] rate, input logic phase);
        int r0;
        logic [7:0] d;
        alt = phase;
        wr(sspt_pkg::ADDR_PORT_G_CFG, {1'b0, phase, 6'h30});
        wr(sspt_pkg::ADDR_CONTROL, {5'h00, rate, 1'b1});
        wr(sspt_pkg::ADDR_SHIFT, 8'hA5 ^ {rate, 6'h00});
        peer_tx = 8'h3C ^ {6'h00, rate};
        go = 1'b1;
        #1 go = 1'b0;
        r0 = rises;
        wr(sspt_pkg::ADDR_STATUS_WORD, 8'h01);
        rdchk("busy", sspt_pkg::ADDR_STATUS_WORD, 8'h01, d);
        wait_idle();
        check("sk rises", 8'(rises - r0), 8'h08);
        check("sk period", 8'(period),
            rate[1] ? 8'h08 : {5'h00, rate[0], ~rate[0], 1'b0});
        check("so byte", peer_rx, 8'hA5 ^ {rate, 6'h00});
        if (rate[1]) begin
            rdchk("si byte", sspt_pkg::ADDR_SHIFT, peer_tx, d);
        end
        check("irq on", {7'h00, irq_out}, 8'h01);
        rdchk("done", sspt_pkg::ADDR_IRQ_STATUS, 8'h01, d);
        rdchk("done clear", sspt_pkg::ADDR_IRQ_STATUS, 8'h00, d);
        check("irq off", {6'h00, sk_out, irq_out}, 8'h00);
    endtask : t_master

    task automatic t_abort();
        int r0;
        logic [7:0] d;
        alt = 1'b0;
        wr(sspt_pkg::ADDR_PORT_G_CFG, 8'h30);
        wr(sspt_pkg::ADDR_CONTROL, 8'h05);
        r0 = rises;
        wr(sspt_pkg::ADDR_STATUS_WORD, 8'h01);
        for (int i = 0; i < 100 && rises - r0 < 3; i++) pause(1);
        wr(sspt_pkg::ADDR_STATUS_WORD, 8'h00);
        pause(2);
        r0 = rises;
        pause(40);
        check("abort rises", 8'(rises - r0), 8'h00);
        check("abort sk", {7'h00, sk_out}, 8'h00);
        rdchk("abort busy", sspt_pkg::ADDR_STATUS_WORD, 8'h00, d);
        rdchk("abort done", sspt_pkg::ADDR_IRQ_STATUS, 8'h00, d);
        wr(sspt_pkg::ADDR_CONTROL, 8'h04);
        r0 = rises;
        wr(sspt_pkg::ADDR_STATUS_WORD, 8'h01);
        pause(40);
        check("off rises", 8'(rises - r0), 8'h00);
        check("off pins", {6'h00, sk_oe, so_oe}, 8'h00);
        wr(sspt_pkg::ADDR_STATUS_WORD, 8'h00);
    endtask : t_abort

    task automatic t_slave();
        logic [7:0] d;
        alt = 1'b0;
        wr(sspt_pkg::ADDR_IRQ_MASK, 8'h00);
        wr(sspt_pkg::ADDR_SHIFT, 8'h96);
        wr(sspt_pkg::ADDR_PORT_G_CFG, 8'h10);
        wr(sspt_pkg::ADDR_CONTROL, 8'h01);
        remote = 1'b1;
        peer_tx = 8'h4B;
        wr(sspt_pkg::ADDR_STATUS_WORD, 8'h01);
        pause(2);
        check("slave oe", {6'h00, sk_oe, so_oe}, 8'h01);
        go = 1'b1;
        #1 go = 1'b0;
        wait_idle();
        check("slave so", peer_rx, 8'h96);
        rdchk("slave si", sspt_pkg::ADDR_SHIFT, 8'h4B, d);
        check("irq masked", {7'h00, irq_out}, 8'h00);
        rdchk("slave done", sspt_pkg::ADDR_IRQ_STATUS, 8'h01, d);
        wr(sspt_pkg::ADDR_PORT_G_CFG, 8'h00);
        pause(2);
        check("so released", {6'h00, sk_oe, so_oe}, 8'h00);
        remote = 1'b0;
    endtask : t_slave

    initial begin
        repeat (16) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        t_reset();
        for (int r = 0; r < 4; r++) t_master(2'(r), 1'b0);
        t_master(2'b10, 1'b1);
        t_abort();
        t_slave();
        conclude();
    end
endmodule : testbench
`default_nettype wire
